//--- rtl/drec_frame_writer.sv
// Frame writer: stores one sample frame as consecutive words into the record store
`timescale 1ns/1ps
module drec_frame_writer (
   input  wire logic                   clk_sys_i,
   input  wire logic                   resetn_i,
   input  wire logic                   ce_i,
   input  wire logic                   start_i,
   input  wire logic [21:0]            adr_i,
   input  wire logic [5:0]             n_an_i,
   input  wire logic [1:0]             n_binw_i,
   input  wire drec_pkg::drec_frame_t  frame_i,
   input  wire logic                   mem_ready_i,
   output drec_pkg::drec_mem_req_t     mem_o,
   output logic                        busy_o
);
   typedef struct packed {
      logic                  busy;
      logic [6:0]            idx;
      logic [6:0]            last;
      logic [5:0]            n_an;
      logic [21:0]           adr;
      logic [31:0]           dat;
      drec_pkg::drec_frame_t frame;
   } drec_wr_t;

   drec_wr_t q, d;

   // Analog words first, then binary words of 32 channels each
   function automatic logic [31:0] word_at(input drec_pkg::drec_frame_t f,
                                           input logic [6:0] i, input logic [5:0] na);
      logic [6:0] b;
      b = i - {1'b0, na};
      if (i < {1'b0, na}) begin
         word_at = {16'h0000, f.an[i[4:0]]};
      end else begin
         word_at = b[0] ? f.bin[63:32] : f.bin[31:0];
      end
   endfunction : word_at

   function automatic logic [21:0] next_adr(input logic [21:0] a);
      next_adr = ({10'h000, a} + 32'h1 >= drec_pkg::CAP_WORDS) ? 22'h0 : a + 22'h1;
   endfunction : next_adr

   always_comb begin
      logic [6:0] tot;
      tot = {1'b0, n_an_i} + {5'h00, n_binw_i};
      d = q;
      if (q.busy && mem_ready_i) begin
         if (q.idx == q.last) begin
            d.busy = 1'b0;
         end else begin
            d.idx = q.idx + 7'h1;
            d.adr = next_adr(q.adr);
            d.dat = word_at(q.frame, q.idx + 7'h1, q.n_an);
         end
      end
      if (start_i && !q.busy && tot != 7'h0) begin
         d.busy  = 1'b1;
         d.idx   = 7'h0;
         d.last  = tot - 7'h1;
         d.n_an  = n_an_i;
         d.adr   = adr_i;
         d.frame = frame_i;
         d.dat   = word_at(frame_i, 7'h0, n_an_i);
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign mem_o.valid = q.busy;
   assign mem_o.adr   = q.adr;
   assign mem_o.dat   = q.dat;
   assign busy_o      = q.busy;
endmodule : drec_frame_writer

//--- rtl/drec_pkg.sv
// Package with constants and types of the disturbance recorder
// Overview of operation
// - Capture starts only when the trigger is true and the enable setting is on.
// - Capture continues while triggered, capped by the recording time limit.
// - At most 64 binary and 32 analog channels per configuration.
// - Record store is bounded to 12 MB; addresses wrap inside it.
// - Base variant samples 20 times per network period.
// - Extended variant may select 40 samples per period; otherwise identical.
// - Storage estimate is 7 kB per analog and 2 kB per binary channel-second.
// - Each record holds the pre-trigger window of samples; the code keeps fewer when the trigger comes before the window has filled.
// - Trigger-active section ends early when the trigger falls.
// - After the trigger-active section, capture runs for the post-trigger window.
// - A new record needs the trigger to have gone false; a held trigger never retriggers.
// - Each record is described by configuration, data and comment parts.
// - Each analog channel takes a raw sample or a calculated quantity.
// - Warning when pre-trigger plus post-trigger window is not below the time limit.
package drec_pkg;
   localparam int unsigned MAX_AN     = 32;
   localparam int unsigned MAX_BIN    = 64;
   localparam int unsigned ADDR_W     = 22;
   localparam int unsigned CAP_BYTES  = 12 * 1024 * 1024;
   localparam logic [31:0] CAP_WORDS  = 32'(CAP_BYTES / 4);
   localparam logic [31:0] KB_PER_AN  = 32'h0000_0007;
   localparam logic [31:0] KB_PER_BIN = 32'h0000_0002;
   localparam logic [11:0] SPS_20_50  = 12'h3E8;
   localparam logic [11:0] SPS_20_60  = 12'h4B0;
   localparam logic [11:0] SPS_40_50  = 12'h7D0;
   localparam logic [11:0] SPS_40_60  = 12'h960;
   localparam logic [31:0] MS_PER_S   = 32'h0000_03E8;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_PRE     = 8'h04;
   localparam logic [7:0] OFS_POST    = 8'h08;
   localparam logic [7:0] OFS_LIMIT   = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h14;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h18;
   localparam logic [7:0] OFS_CHANS   = 8'h1C;
   localparam logic [7:0] OFS_SRC_SEL = 8'h20;
   localparam logic [7:0] OFS_NOTE    = 8'h24;
   localparam logic [7:0] OFS_REC_CFG = 8'h28;
   localparam logic [7:0] OFS_REC_ADR = 8'h2C;
   localparam logic [7:0] OFS_REC_ROT = 8'h30;
   localparam logic [7:0] OFS_REC_PRE = 8'h34;
   localparam logic [7:0] OFS_REC_TOT = 8'h38;
   localparam logic [7:0] OFS_REC_NTE = 8'h3C;
   localparam logic [7:0] OFS_EST_KBS = 8'h40;
   // Field positions
   localparam int unsigned CTRL_EN    = 0;
   localparam int unsigned CTRL_R40   = 1;
   localparam int unsigned CTRL_F60   = 2;
   localparam int unsigned IRQ_DONE   = 0;
   localparam int unsigned IRQ_WARN   = 1;
   localparam int unsigned IRQ_OVR    = 2;
   localparam int unsigned IRQ_W      = 3;
   // Reset values
   localparam logic [13:0] RST_PRE_MS   = 14'h00C8;
   localparam logic [13:0] RST_POST_MS  = 14'h00C8;
   localparam logic [13:0] RST_LIMIT_MS = 14'h03E8;
   localparam logic [5:0]  RST_N_AN     = 6'h20;
   localparam logic [6:0]  RST_N_BIN    = 7'h40;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TRIG = 2'b01,
      ST_POST = 2'b10
   } drec_state_t;

   typedef struct packed {
      logic [MAX_AN-1:0][15:0] raw;
      logic [MAX_AN-1:0][15:0] calc;
      logic [MAX_BIN-1:0]      bin;
   } drec_chan_in_t;

   typedef struct packed {
      logic [MAX_AN-1:0][15:0] an;
      logic [MAX_BIN-1:0]      bin;
   } drec_frame_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } drec_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } drec_wb_rsp_t;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] adr;
      logic [31:0]       dat;
   } drec_mem_req_t;
endpackage : drec_pkg

//--- rtl/drec_recorder.sv
// Disturbance recorder core with Wishbone register file
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
module drec_recorder #(
   parameter bit EXTENDED_RATE_RECORDER_VARIANT = 1'b0
) (
   input  wire logic                    clk_sys_i,
   input  wire logic                    resetn_i,
   input  wire logic                    ce_i,
   input  wire drec_pkg::drec_wb_req_t  wb_i,
   output drec_pkg::drec_wb_rsp_t       wb_o,
   input  wire logic                    sample_stb_i,
   input  wire drec_pkg::drec_chan_in_t chan_i,
   input  wire logic                    trigger_i,
   input  wire logic                    mem_ready_i,
   output drec_pkg::drec_mem_req_t      mem_o,
   output logic                         recording_o,
   output logic                         warn_o,
   output logic                         irq_o
);
   typedef struct packed {
      logic                  ack;
      logic [31:0]           rdat;
      logic [2:0]            ctrl;
      logic [13:0]           pre_ms;
      logic [13:0]           post_ms;
      logic [13:0]           lim_ms;
      logic [5:0]            n_an;
      logic [6:0]            n_bin;
      logic [31:0]           src_sel;
      logic [31:0]           note;
      logic [2:0]            irq_st;
      logic [2:0]            irq_msk;
      logic                  warn;
      drec_pkg::drec_state_t st;
      logic                  dec;
      logic                  rearmed;
      logic [21:0]           base;
      logic [21:0]           lin;
      logic [23:0]           slot;
      logic [23:0]           fill;
      logic [23:0]           rot;
      logic [23:0]           pre_n;
      logic [23:0]           act_n;
      logic [23:0]           post_n;
      logic [31:0]           rec_cfg;
      logic [21:0]           rec_adr;
      logic [23:0]           rec_rot;
      logic [23:0]           rec_pre;
      logic [23:0]           rec_tot;
      logic [31:0]           rec_note;
   } drec_core_t;

   drec_core_t            q, d;
   drec_pkg::drec_frame_t frame;
   logic                  wr_busy;
   logic                  wr_go;
   logic [21:0]           wr_adr;
   logic                  eff40;
   logic [11:0]           sps;
   logic [23:0]           pre_s;
   logic [23:0]           post_s;
   logic [23:0]           lim_s;
   logic [1:0]            binw;
   logic [6:0]            fwords;
   logic [31:0]           ring_w;
   logic [31:0]           est_kbs;

   function automatic logic [23:0] ms_to_samp(input logic [13:0] ms, input logic [11:0] r);
      logic [31:0] p;
      p = ({18'h0, ms} * {20'h0, r}) / drec_pkg::MS_PER_S;
      ms_to_samp = p[23:0];
   endfunction : ms_to_samp

   function automatic logic [21:0] adr_add(input logic [21:0] a, input logic [31:0] b);
      logic [31:0] s;
      s = {10'h000, a} + b;
      if (s >= drec_pkg::CAP_WORDS) begin
         s = s - drec_pkg::CAP_WORDS;
      end
      adr_add = s[21:0];
   endfunction : adr_add

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = sel[i] ? n[i*8 +: 8] : o[i*8 +: 8];
      end
   endfunction : merge

   // Per-channel source selection between raw and calculated values
   genvar g;
   generate
      for (g = 0; g < drec_pkg::MAX_AN; g++) begin : g_src
         assign frame.an[g] = q.src_sel[g] ? chan_i.calc[g] : chan_i.raw[g];
      end
   endgenerate
   assign frame.bin = chan_i.bin;

   assign eff40 = EXTENDED_RATE_RECORDER_VARIANT & q.ctrl[drec_pkg::CTRL_R40];
   always_comb begin
      unique case ({eff40, q.ctrl[drec_pkg::CTRL_F60]})
         2'b00: sps = drec_pkg::SPS_20_50;
         2'b01: sps = drec_pkg::SPS_20_60;
         2'b10: sps = drec_pkg::SPS_40_50;
         2'b11: sps = drec_pkg::SPS_40_60;
      endcase
   end

   assign pre_s   = ms_to_samp(q.pre_ms, sps);
   assign post_s  = ms_to_samp(q.post_ms, sps);
   assign lim_s   = ms_to_samp(q.lim_ms, sps);
   assign binw    = (q.n_bin == 7'h00) ? 2'h0 : ((q.n_bin > 7'h20) ? 2'h2 : 2'h1);
   assign fwords  = {1'b0, q.n_an} + {5'h00, binw};
   assign ring_w  = 32'(pre_s * {17'h0, fwords});
   assign est_kbs = 32'({26'h0, q.n_an} * drec_pkg::KB_PER_AN)
                  + 32'({25'h0, q.n_bin} * drec_pkg::KB_PER_BIN);

   always_comb begin
      logic        acc;
      logic        keep;
      logic [2:0]  set;
      logic [2:0]  clr;
      logic [5:0]  na;
      logic [6:0]  nb;
      logic [23:0] tot;
      d      = q;
      set    = 3'h0;
      clr    = 3'h0;
      na     = 6'h0;
      nb     = 7'h0;
      wr_go  = 1'b0;
      wr_adr = q.lin;
      tot    = q.pre_n + q.act_n + q.post_n;
      acc    = wb_i.cyc & wb_i.stb & ~q.ack;
      d.ack  = acc;
      d.rdat = 32'h0;
      if (acc && wb_i.we) begin
         unique case (wb_i.adr)
            drec_pkg::OFS_CTRL: d.ctrl = 3'(merge({29'h0, q.ctrl}, wb_i.dat, wb_i.sel));
            drec_pkg::OFS_PRE: d.pre_ms = 14'(merge({18'h0, q.pre_ms}, wb_i.dat, wb_i.sel));
            drec_pkg::OFS_POST: d.post_ms = 14'(merge({18'h0, q.post_ms}, wb_i.dat, wb_i.sel));
            drec_pkg::OFS_LIMIT: d.lim_ms = 14'(merge({18'h0, q.lim_ms}, wb_i.dat, wb_i.sel));
            drec_pkg::OFS_IRQ_ST: clr = 3'(merge(32'h0, wb_i.dat, wb_i.sel));
            drec_pkg::OFS_IRQ_MSK: d.irq_msk = 3'(merge({29'h0, q.irq_msk}, wb_i.dat, wb_i.sel));
            drec_pkg::OFS_CHANS: begin
               na = 6'(merge({17'h0, q.n_bin, 2'h0, q.n_an}, wb_i.dat, wb_i.sel));
               nb = 7'(merge({17'h0, q.n_bin, 2'h0, q.n_an}, wb_i.dat, wb_i.sel) >> 8);
               d.n_an  = (na > 6'h20) ? 6'h20 : na;
               d.n_bin = (nb > 7'h40) ? 7'h40 : nb;
            end
            drec_pkg::OFS_SRC_SEL: d.src_sel = merge(q.src_sel, wb_i.dat, wb_i.sel);
            drec_pkg::OFS_NOTE: d.note = merge(q.note, wb_i.dat, wb_i.sel);
            default: ;
         endcase
      end
      if (acc && !wb_i.we) begin
         unique case (wb_i.adr)
            drec_pkg::OFS_CTRL: d.rdat = {29'h0, q.ctrl};
            drec_pkg::OFS_PRE: d.rdat = {18'h0, q.pre_ms};
            drec_pkg::OFS_POST: d.rdat = {18'h0, q.post_ms};
            drec_pkg::OFS_LIMIT: d.rdat = {18'h0, q.lim_ms};
            drec_pkg::OFS_STATUS: d.rdat = {27'h0, wr_busy, q.rearmed, q.warn, q.st};
            drec_pkg::OFS_IRQ_ST: d.rdat = {29'h0, q.irq_st};
            drec_pkg::OFS_IRQ_MSK: d.rdat = {29'h0, q.irq_msk};
            drec_pkg::OFS_CHANS: d.rdat = {17'h0, q.n_bin, 2'h0, q.n_an};
            drec_pkg::OFS_SRC_SEL: d.rdat = q.src_sel;
            drec_pkg::OFS_NOTE: d.rdat = q.note;
            drec_pkg::OFS_REC_CFG: d.rdat = q.rec_cfg;
            drec_pkg::OFS_REC_ADR: d.rdat = {10'h0, q.rec_adr};
            drec_pkg::OFS_REC_ROT: d.rdat = {8'h0, q.rec_rot};
            drec_pkg::OFS_REC_PRE: d.rdat = {8'h0, q.rec_pre};
            drec_pkg::OFS_REC_TOT: d.rdat = {8'h0, q.rec_tot};
            drec_pkg::OFS_REC_NTE: d.rdat = q.rec_note;
            drec_pkg::OFS_EST_KBS: d.rdat = est_kbs;
            default: d.rdat = 32'h0;
         endcase
      end

      // Settings check
      d.warn = ({1'b0, q.pre_ms} + {1'b0, q.post_ms}) >= {1'b0, q.lim_ms};
      if (d.warn && !q.warn) begin
         set[drec_pkg::IRQ_WARN] = 1'b1;
      end

      // Sample decimation: every strobe at 40, every other at 20
      keep = 1'b0;
      if (sample_stb_i) begin
         d.dec = ~q.dec;
         keep  = eff40 | q.dec;
      end
      if (!trigger_i) begin
         d.rearmed = 1'b1;
      end

      if (keep && wr_busy && (q.st != drec_pkg::ST_IDLE || q.ctrl[drec_pkg::CTRL_EN])) begin
         set[drec_pkg::IRQ_OVR] = 1'b1;
      end

      unique case (q.st)
         drec_pkg::ST_IDLE: begin
            if (!q.ctrl[drec_pkg::CTRL_EN] || pre_s == 24'h0) begin
               d.slot = 24'h0;
               d.fill = 24'h0;
            end
            if (q.ctrl[drec_pkg::CTRL_EN] && trigger_i && q.rearmed && !q.warn) begin
               d.st      = drec_pkg::ST_TRIG;
               d.rearmed = 1'b0;
               d.pre_n   = q.fill;
               d.rot     = (q.fill == pre_s) ? q.slot : 24'h0;
               d.lin     = adr_add(q.base, ring_w);
               d.act_n   = 24'h0;
               d.post_n  = 24'h0;
            end else if (keep && !wr_busy && q.ctrl[drec_pkg::CTRL_EN] && pre_s != 24'h0) begin
               wr_go  = 1'b1;
               wr_adr = adr_add(q.base, 32'(q.slot * {17'h0, fwords}));
               d.slot = (q.slot + 24'h1 >= pre_s) ? 24'h0 : q.slot + 24'h1;
               d.fill = (q.fill >= pre_s) ? pre_s : q.fill + 24'h1;
            end
         end
         drec_pkg::ST_TRIG: begin
            if (keep && !wr_busy) begin
               wr_go   = 1'b1;
               d.lin   = adr_add(q.lin, {25'h0, fwords});
               d.act_n = q.act_n + 24'h1;
            end
            if (!trigger_i || d.act_n >= lim_s) begin
               d.st = drec_pkg::ST_POST;
            end
         end
         drec_pkg::ST_POST: begin
            if (keep && !wr_busy) begin
               wr_go    = 1'b1;
               d.lin    = adr_add(q.lin, {25'h0, fwords});
               d.post_n = q.post_n + 24'h1;
            end
            if (d.post_n >= post_s) begin
               d.st       = drec_pkg::ST_IDLE;
               d.rec_cfg  = {9'h0, q.note[7:0], q.ctrl[2:1], q.n_bin, q.n_an};
               d.rec_adr  = q.base;
               d.rec_rot  = q.rot;
               d.rec_pre  = q.pre_n;
               d.rec_tot  = tot + (d.post_n - q.post_n);
               d.rec_note = q.note;
               d.base     = d.lin;
               d.slot     = 24'h0;
               d.fill     = 24'h0;
               set[drec_pkg::IRQ_DONE] = 1'b1;
            end
         end
         default: d.st = drec_pkg::ST_IDLE;
      endcase
      d.irq_st = (q.irq_st & ~clr) | set;
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q         <= '0;
         q.pre_ms  <= drec_pkg::RST_PRE_MS;
         q.post_ms <= drec_pkg::RST_POST_MS;
         q.lim_ms  <= drec_pkg::RST_LIMIT_MS;
         q.n_an    <= drec_pkg::RST_N_AN;
         q.n_bin   <= drec_pkg::RST_N_BIN;
         q.st      <= drec_pkg::ST_IDLE;
      end else if (ce_i) begin
         q <= d;
      end
   end

   drec_frame_writer u_writer (
      .clk_sys_i   (clk_sys_i),
      .resetn_i    (resetn_i),
      .ce_i        (ce_i),
      .start_i     (wr_go),
      .adr_i       (wr_adr),
      .n_an_i      (q.n_an),
      .n_binw_i    (binw),
      .frame_i     (frame),
      .mem_ready_i (mem_ready_i),
      .mem_o       (mem_o),
      .busy_o      (wr_busy)
   );

   assign wb_o.ack    = q.ack;
   assign wb_o.dat    = q.rdat;
   assign recording_o = (q.st != drec_pkg::ST_IDLE);
   assign warn_o      = q.warn;
   assign irq_o       = |(q.irq_st & q.irq_msk);
endmodule : drec_recorder

//--- test/drec_chk.sv
// Assertion checker for the disturbance recorder ports
`timescale 1ns/1ps
module drec_chk (
   input wire logic                    clk_sys_i,
   input wire logic                    resetn_i,
   input wire logic                    ce_i,
   input wire drec_pkg::drec_wb_req_t  wb_i,
   input wire drec_pkg::drec_wb_rsp_t  wb_o,
   input wire logic                    trigger_i,
   input wire drec_pkg::drec_mem_req_t mem_o,
   input wire logic                    recording_o,
   input wire logic                    warn_o
);
   logic low_seen_q;
   logic rec_q;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   // Remembers a low trigger since the last record start
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         low_seen_q <= 1'b0;
         rec_q      <= 1'b0;
      end else begin
         rec_q      <= recording_o;
         low_seen_q <= !trigger_i || (low_seen_q && !(recording_o && !rec_q));
      end
   end
   sequence req_s;
      wb_i.cyc && wb_i.stb && !wb_o.ack;
   endsequence
   sequence start_s;
      $rose(recording_o);
   endsequence
   ack_answer_a: assert property ((ce_i and req_s) |=> wb_o.ack)
      else $error("bus request not answered in one cycle");
   ack_pulse_a: assert property (wb_o.ack && ce_i |=> !wb_o.ack)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property ($rose(wb_o.ack) |-> $past(wb_i.cyc && wb_i.stb))
      else $error("ack without request");
   dat_idle_a: assert property (!wb_o.ack |-> wb_o.dat == 32'h0)
      else $error("read data outside ack");
   rec_start_a: assert property (start_s |-> $past(trigger_i && ce_i))
      else $error("record started without trigger");
   rec_rearm_a: assert property (start_s |-> low_seen_q)
      else $error("held trigger started a record");
   rec_warn_a: assert property (start_s |-> !$past(warn_o))
      else $error("record started with invalid settings");
   mem_bound_a: assert property (mem_o.valid |-> 32'(mem_o.adr) < drec_pkg::CAP_WORDS)
      else $error("store address beyond capacity");
   ce_freeze_a: assert property (!ce_i |=> $stable(recording_o) && $stable(mem_o) && $stable(wb_o))
      else $error("state moved while clock enable low");
endmodule : drec_chk
bind drec_recorder drec_chk drec_chk_inst (.clk_sys_i, .resetn_i, .ce_i, .wb_i, .wb_o,
   .trigger_i, .mem_o, .recording_o, .warn_o);

//--- test/drec_src_model.sv
// Channel source and record store model for the disturbance recorder
`timescale 1ns/1ps
module drec_src_model #(
   parameter int unsigned PERIOD = 16
) (
   input  wire logic               clk_sys_i,
   input  wire logic               resetn_i,
   input  wire logic [31:0]        rnd_i,
   output logic                    sample_stb_o,
   output drec_pkg::drec_chan_in_t chan_o,
   output logic                    mem_ready_o
);
   int unsigned cnt;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt          <= 0;
         sample_stb_o <= 1'b0;
         mem_ready_o  <= 1'b0;
         chan_o       <= '0;
      end else begin
         cnt          <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         sample_stb_o <= (cnt == 0);
         mem_ready_o  <= rnd_i[0] | rnd_i[1];
         for (int i = 0; i < 32; i++) begin
            chan_o.raw[i]  <= rnd_i[15:0] ^ 16'(i);
            chan_o.calc[i] <= rnd_i[31:16] + 16'(i);
         end
         chan_o.bin <= {rnd_i, ~rnd_i};
      end
   end
endmodule : drec_src_model

//--- test/tb_top.sv
// Self-checking testbench of the disturbance recorder
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic [31:0] val;
      logic [31:0] msk;
      logic        lt;
   } drec_exp_t;
   logic                    clk_sys_i;
   logic                    resetn_i;
   logic                    ce_i;
   logic                    trigger_i;
   logic                    sample_stb;
   logic                    mem_ready;
   logic                    recording;
   logic                    warn;
   logic                    irq;
   logic [31:0]             rnd;
   drec_pkg::drec_wb_req_t  wb_req;
   drec_pkg::drec_wb_rsp_t  wb_rsp;
   drec_pkg::drec_chan_in_t chan;
   drec_pkg::drec_mem_req_t mem;
   drec_exp_t               exp_q[$];
   int                      mismatches;
   int                      n_checks;
   int                      cycles;
   logic [39:0] rst_tab [8] = '{{8'h00, 32'h0}, {8'h04, 32'hC8}, {8'h08, 32'hC8},
      {8'h0C, 32'h3E8}, {8'h18, 32'h0}, {8'h1C, 32'h4020}, {8'h40, 32'h160}, {8'h44, 32'h0}};
   // Mode table: ctrl, pre samples, bound on total samples
   logic [19:0] mode_tab [4] = '{20'h1_05_12, 20'h5_06_15, 20'h3_0A_24, 20'h7_0C_2B};

   drec_recorder #(.EXTENDED_RATE_RECORDER_VARIANT(1'b1)) drec_recorder_inst (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_i), .wb_i(wb_req), .wb_o(wb_rsp),
      .sample_stb_i(sample_stb), .chan_i(chan), .trigger_i(trigger_i), .mem_ready_i(mem_ready),
      .mem_o(mem), .recording_o(recording), .warn_o(warn), .irq_o(irq));
   drec_src_model #(.PERIOD(16)) drec_src_model_inst (.clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i), .rnd_i(rnd), .sample_stb_o(sample_stb), .chan_o(chan),
      .mem_ready_o(mem_ready));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   task automatic test_done();
      if (mismatches == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   task automatic check_bit(input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : check_bit
   task automatic check_rd(input drec_exp_t e, input logic [31:0] g);
      logic ok;
      n_checks++;
      ok = e.lt ? (((g & e.msk) < e.val) === 1'b1) : ((g & e.msk) === e.val);
      if (!ok) begin
         mismatches++;
         $display("BAD t=%0t exp=%h got=%h", $time, e.val, g);
      end
   endtask : check_rd
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m = 32'hFFFF_FFFF, input logic lt = 1'b0);
      if (!we) begin
         exp_q.push_back('{val: d, msk: m, lt: lt});
      end
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: we ? d : 32'h0};
      do @(posedge clk_sys_i); while (wb_rsp.ack !== 1'b1);
      wb_req <= '0;
      @(posedge clk_sys_i);
   endtask : xfer
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : cyc
   task automatic wait_rec(input logic v, input int n);
      int k;
      k = 0;
      while (recording !== v && k < n) begin
         @(posedge clk_sys_i);
         k++;
      end
   endtask : wait_rec

   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      rnd <= xorshift(rnd);
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
      if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) begin
         check_rd(exp_q.pop_front(), wb_rsp.dat);
      end
   end
   initial begin
      logic [31:0] v;
      resetn_i = 1'b0;
      ce_i = 1'b1;
      trigger_i = 1'b0;
      wb_req = '0;
      rnd = 32'hB018_3419;
      mismatches = 0;
      n_checks = 0;
      cycles = 0;
      cyc(20);
      resetn_i <= 1'b1;
      cyc(1);
      check_bit(1'b0, warn);
      foreach (rst_tab[i]) xfer(1'b0, rst_tab[i][39:32], rst_tab[i][31:0]);
      ce_i <= 1'b0;
      cyc(6);
      ce_i <= 1'b1;
      xfer(1'b1, 8'h44, 32'hFFFF_FFFF);
      xfer(1'b0, 8'h44, 32'h0);
      xfer(1'b1, drec_pkg::OFS_CHANS, 32'h7F3F);
      xfer(1'b0, drec_pkg::OFS_CHANS, 32'h4020);
      xfer(1'b1, drec_pkg::OFS_CHANS, 32'h0503);
      xfer(1'b0, drec_pkg::OFS_EST_KBS, 32'h1F);
      v = rnd;
      xfer(1'b1, drec_pkg::OFS_SRC_SEL, v);
      xfer(1'b0, drec_pkg::OFS_SRC_SEL, v);
      xfer(1'b1, drec_pkg::OFS_NOTE, 32'hA5);
      xfer(1'b1, drec_pkg::OFS_PRE, 32'h5);
      xfer(1'b1, drec_pkg::OFS_POST, 32'h5);
      xfer(1'b1, drec_pkg::OFS_LIMIT, 32'hA);
      cyc(2);
      check_bit(1'b1, warn);
      xfer(1'b1, drec_pkg::OFS_CTRL, 32'h1);
      trigger_i <= 1'b1;
      cyc(300);
      check_bit(1'b0, recording);
      trigger_i <= 1'b0;
      xfer(1'b1, drec_pkg::OFS_POST, 32'h3);
      cyc(2);
      check_bit(1'b0, warn);
      xfer(1'b0, drec_pkg::OFS_IRQ_ST, 32'h2, 32'h2);
      cyc(300);
      trigger_i <= 1'b1;
      wait_rec(1'b1, 60);
      check_bit(1'b1, recording);
      wait_rec(1'b0, 3000);
      check_bit(1'b0, recording);
      xfer(1'b0, drec_pkg::OFS_REC_PRE, 32'h5);
      xfer(1'b0, drec_pkg::OFS_REC_TOT, 32'h12);
      xfer(1'b0, drec_pkg::OFS_REC_CFG, 32'h0052_8143);
      check_bit(1'b0, irq);
      xfer(1'b0, drec_pkg::OFS_IRQ_ST, 32'h1, 32'h1);
      cyc(400);
      check_bit(1'b0, recording);
      xfer(1'b0, drec_pkg::OFS_STATUS, 32'h0, 32'hF);
      xfer(1'b1, drec_pkg::OFS_IRQ_MSK, 32'h1);
      cyc(2);
      check_bit(1'b1, irq);
      xfer(1'b1, drec_pkg::OFS_IRQ_ST, 32'h1);
      cyc(2);
      check_bit(1'b0, irq);
      foreach (mode_tab[i]) begin
         xfer(1'b1, drec_pkg::OFS_CTRL, {28'h0, mode_tab[i][19:16]});
         trigger_i <= 1'b0;
         cyc(500);
         trigger_i <= 1'b1;
         cyc(40);
         check_bit(1'b1, recording);
         trigger_i <= 1'b0;
         wait_rec(1'b0, 2000);
         check_bit(1'b0, recording);
         xfer(1'b0, drec_pkg::OFS_REC_PRE, {24'h0, mode_tab[i][15:8]});
         xfer(1'b0, drec_pkg::OFS_REC_TOT, 32'(mode_tab[i][7:0]), 32'hFFFF_FFFF, 1'b1);
      end
      test_done();
   end
endmodule : tb_top
